// *** src/lprc_pkg.sv ***
package lprc_pkg;

    // Domain power modes, one-hot.
    typedef enum logic [2:0] {
        LPRC_DOM_RUN = 3'h1,
        LPRC_DOM_HALT = 3'h2,
        LPRC_DOM_OFF = 3'h4
    } lprc_dom_t;

    // System power modes, one-hot.
    typedef enum logic [2:0] {
        LPRC_SYS_RUN = 3'h1,
        LPRC_SYS_STOP = 3'h2,
        LPRC_SYS_STANDBY = 3'h4
    } lprc_sys_t;

    // CPU state, one-hot.
    typedef enum logic [2:0] {
        LPRC_CPU_RUN = 3'h1,
        LPRC_CPU_CLOCK_HALT = 3'h2,
        LPRC_CPU_SUBSYS_HALT = 3'h4
    } lprc_cpu_t;

    // Supervisor flags after synchronisation.
    typedef struct packed {
        logic por_low;
        logic pdr_low;
        logic bor_low_1;
        logic bor_low_2;
        logic bor_low_3;
        logic ext_pin_n;
    } lprc_sup_t;

    // Digital reset causes other than supervisors.
    typedef struct packed {
        logic window_wdg;
        logic indep_wdg;
        logic software;
        logic lp_security;
    } lprc_cause_t;

    localparam int LPRC_SYNC_STAGES = 3;
    localparam int LPRC_SUP_W = 6;
    localparam logic [1:0] LPRC_VOS_BOOST = 2'h0;
    localparam logic [1:0] LPRC_STOP_VOLTAGE_SCALE_3 = 2'h0;
    localparam logic [1:0] LPRC_BOR_SEL_1 = 2'h0;
    localparam logic [1:0] LPRC_BOR_SEL_2 = 2'h1;
    localparam logic [1:0] LPRC_CLK_INTERNAL = 2'h0;
    localparam logic [3:0] LPRC_RST_STRETCH = 4'h8;
    localparam logic [3:0] LPRC_CLK_RESTART = 4'h4;

endpackage : lprc_pkg

// *** src/lprc_low_power_reset_control.sv ***
// Contract
// - A wait instruction or sleep-on-return halts the CPU.
// - A domain sleeps only when its CPU, subsystem and peripherals are low.
// - While any part of a domain is active the domain keeps its mode.
// - System stop or standby needs no pending wakeup and the CPU and peripheral domains low.
// - Run: control domain runs; stop: it halts; standby: all domains off.
// - Reset holds while the power-on supervisor reports low supply.
// - The power-down supervisor, enabled by its pin, resets on low supply.
// - Brownout resets below one of three option-selected thresholds.
// - Power-on reset clears all; system reset spares retained state.
// - Every listed cause, standby exit included, raises system reset.
// - Reset selects the internal fast oscillator; only software changes it.
// - Run voltage scale is a four-level field.
// - Stop scale 3 keeps wake peripherals on; scales 4 and 5 turn them off.
// - CPU and peripheral domains power off alone; control domain powers off only in system standby.
`timescale 1ns/1ps
`default_nettype none

module lprc_low_power_reset_control (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Core requests and domain readiness.
    input wire logic wait_interrupt_instruction_in,
    input wire logic wait_event_instruction_in,
    input wire logic handler_return_in,
    input wire logic sleep_on_handler_return_in,
    input wire logic deep_sleep_in,
    input wire logic cpu_domain_periph_idle_in,
    input wire logic peripheral_domain_periph_idle_in,
    input wire logic peripheral_domain_cpu_idle_in,
    input wire logic cpu_domain_standby_in,
    input wire logic peripheral_domain_standby_in,
    input wire logic system_standby_in,
    input wire logic wakeup_pending_in,
    input wire logic wakeup_event_in,
    // Supervisors and pins, asynchronous.
    input wire logic por_low_in,
    input wire logic pdr_low_in,
    input wire logic supervisor_enable_pin_in,
    input wire logic [2:0] bor_low_in,
    input wire logic external_reset_pin_n_in,
    // Option bytes and software control.
    input wire logic [1:0] bor_level_sel_in,
    input wire lprc_pkg::lprc_cause_t cause_in,
    input wire logic [1:0] run_voltage_scale_in,
    input wire logic [1:0] stop_voltage_scale_in,
    input wire logic clk_sel_write_in,
    input wire logic [1:0] clk_sel_in,
    // Outputs.
    output logic [2:0] cpu_state_out,
    output logic [2:0] cpu_domain_state_out,
    output logic [2:0] peripheral_domain_state_out,
    output logic [2:0] system_control_domain_state_out,
    output logic [2:0] system_state_out,
    output logic system_reset_n_out,
    output logic por_reset_n_out,
    output logic [1:0] voltage_scale_out,
    output logic [1:0] stop_scale_out,
    output logic wake_periph_enable_out,
    output logic [1:0] clk_sel_out,
    output logic clocks_running_out,
    output logic cpu_resume_out
);

    localparam int SW = lprc_pkg::LPRC_SUP_W;

    // Reset release through two flops.
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Asynchronous inputs pass three flops; stages two and three must agree.
    logic [SW-1:0] sup_raw;
    logic [SW-1:0] s1_r, s2_r, s3_r, sup_r, sup_nxt;
    assign sup_raw = {por_low_in, pdr_low_in & supervisor_enable_pin_in,
                      bor_low_in, ~external_reset_pin_n_in};
    always_comb begin
        sup_nxt = sup_r;
        for (int i = 0; i < SW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                sup_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            sup_r <= '0;
        end else begin
            s1_r <= sup_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sup_r <= sup_nxt;
        end
    end

    lprc_pkg::lprc_sup_t sup;
    assign sup = sup_r;

    // Brownout compares against the option-selected level only.
    logic bor_hit;
    always_comb begin
        case (bor_level_sel_in)
            lprc_pkg::LPRC_BOR_SEL_1: bor_hit = sup.bor_low_1;
            lprc_pkg::LPRC_BOR_SEL_2: bor_hit = sup.bor_low_2;
            default: bor_hit = sup.bor_low_3;
        endcase
    end

    // Power-on reset covers everything; kept separate so retained state
    // survives a plain system reset.
    logic por_n_r, por_n_nxt;
    assign por_n_nxt = ~sup.por_low;

    lprc_pkg::lprc_sys_t sys_r, sys_nxt;
    logic standby_exit;
    logic any_cause;
    assign standby_exit = (sys_r == lprc_pkg::LPRC_SYS_STANDBY)
                          && wakeup_event_in;
    assign any_cause = sup.por_low || sup.pdr_low || bor_hit
                       || sup.ext_pin_n || cause_in.window_wdg
                       || cause_in.indep_wdg || cause_in.software
                       || cause_in.lp_security || standby_exit;

    // Reset stretch so short cause pulses still give a full reset.
    logic [3:0] rst_cnt_r, rst_cnt_nxt;
    logic sys_rst_n_r, sys_rst_n_nxt;
    always_comb begin
        rst_cnt_nxt = rst_cnt_r;
        if (any_cause) begin
            rst_cnt_nxt = lprc_pkg::LPRC_RST_STRETCH;
        end else if (rst_cnt_r != 4'h0) begin
            rst_cnt_nxt = rst_cnt_r - 4'h1;
        end
        sys_rst_n_nxt = !any_cause && (rst_cnt_r == 4'h0);
    end

    // Clock select; forced to internal by system reset and by power-on.
    logic [1:0] clk_sel_r, clk_sel_nxt;
    always_comb begin
        clk_sel_nxt = clk_sel_r;
        if (!sys_rst_n_r) begin
            clk_sel_nxt = lprc_pkg::LPRC_CLK_INTERNAL;
        end else if (clk_sel_write_in) begin
            clk_sel_nxt = clk_sel_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            por_n_r <= 1'b0;
            rst_cnt_r <= lprc_pkg::LPRC_RST_STRETCH;
            sys_rst_n_r <= 1'b0;
        end else begin
            por_n_r <= por_n_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            sys_rst_n_r <= sys_rst_n_nxt;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            clk_sel_r <= lprc_pkg::LPRC_CLK_INTERNAL;
        end else if (!por_n_r) begin
            clk_sel_r <= lprc_pkg::LPRC_CLK_INTERNAL;
        end else begin
            clk_sel_r <= clk_sel_nxt;
        end
    end

    // Power state machines.
    lprc_pkg::lprc_cpu_t cpu_r, cpu_nxt;
    lprc_pkg::lprc_dom_t d1_r, d1_nxt, d2_r, d2_nxt, d3_r, d3_nxt;
    logic [3:0] restart_cnt_r, restart_cnt_nxt;
    logic clocks_r, clocks_nxt;
    logic resume_r, resume_nxt;
    logic [1:0] vos_r, vos_nxt, stop_voltage_scale_r, stop_voltage_scale_nxt;
    logic wake_en_r, wake_en_nxt;
    logic cpu_req, cpu_low, d1_low, d2_low, doms_low;

    assign cpu_req = wait_interrupt_instruction_in
                     || wait_event_instruction_in
                     || (handler_return_in && sleep_on_handler_return_in);
    assign cpu_low = (cpu_r != lprc_pkg::LPRC_CPU_RUN);
    assign d1_low = (cpu_r == lprc_pkg::LPRC_CPU_SUBSYS_HALT)
                    && cpu_domain_periph_idle_in;
    assign d2_low = peripheral_domain_cpu_idle_in
                    && peripheral_domain_periph_idle_in;
    assign doms_low = (d1_r != lprc_pkg::LPRC_DOM_RUN)
                      && (d2_r != lprc_pkg::LPRC_DOM_RUN);

    always_comb begin
        cpu_nxt = cpu_r;
        d1_nxt = d1_r;
        d2_nxt = d2_r;
        d3_nxt = d3_r;
        sys_nxt = sys_r;
        restart_cnt_nxt = restart_cnt_r;
        clocks_nxt = clocks_r;
        resume_nxt = 1'b0;
        vos_nxt = run_voltage_scale_in;
        stop_voltage_scale_nxt = stop_voltage_scale_in;
        wake_en_nxt = wake_en_r;
        if (wakeup_event_in
            && (cpu_low || sys_r != lprc_pkg::LPRC_SYS_RUN)) begin
            // Clocks and domains come back first; CPU waits the restart count.
            sys_nxt = lprc_pkg::LPRC_SYS_RUN;
            d1_nxt = lprc_pkg::LPRC_DOM_RUN;
            d2_nxt = lprc_pkg::LPRC_DOM_RUN;
            d3_nxt = lprc_pkg::LPRC_DOM_RUN;
            clocks_nxt = 1'b1;
            wake_en_nxt = 1'b1;
            restart_cnt_nxt = lprc_pkg::LPRC_CLK_RESTART;
        end else if (restart_cnt_r != 4'h0) begin
            restart_cnt_nxt = restart_cnt_r - 4'h1;
            if (restart_cnt_r == 4'h1) begin
                cpu_nxt = lprc_pkg::LPRC_CPU_RUN;
                resume_nxt = 1'b1;
            end
        end else begin
            case (cpu_r)
                lprc_pkg::LPRC_CPU_RUN: begin
                    if (cpu_req) begin
                        cpu_nxt = deep_sleep_in
                                  ? lprc_pkg::LPRC_CPU_SUBSYS_HALT
                                  : lprc_pkg::LPRC_CPU_CLOCK_HALT;
                    end
                end
                lprc_pkg::LPRC_CPU_CLOCK_HALT: cpu_nxt = cpu_r;
                lprc_pkg::LPRC_CPU_SUBSYS_HALT: cpu_nxt = cpu_r;
                default: cpu_nxt = lprc_pkg::LPRC_CPU_RUN;
            endcase
            // Each domain decides alone; the control domain follows the system mode.
            if (d1_r == lprc_pkg::LPRC_DOM_RUN && d1_low) begin
                d1_nxt = cpu_domain_standby_in ? lprc_pkg::LPRC_DOM_OFF
                                               : lprc_pkg::LPRC_DOM_HALT;
            end
            if (d2_r == lprc_pkg::LPRC_DOM_RUN && d2_low) begin
                d2_nxt = peripheral_domain_standby_in
                         ? lprc_pkg::LPRC_DOM_OFF : lprc_pkg::LPRC_DOM_HALT;
            end
            if (sys_r == lprc_pkg::LPRC_SYS_RUN && doms_low
                && !wakeup_pending_in) begin
                if (system_standby_in && d1_r == lprc_pkg::LPRC_DOM_OFF
                    && d2_r == lprc_pkg::LPRC_DOM_OFF) begin
                    sys_nxt = lprc_pkg::LPRC_SYS_STANDBY;
                    d3_nxt = lprc_pkg::LPRC_DOM_OFF;
                end else begin
                    sys_nxt = lprc_pkg::LPRC_SYS_STOP;
                    d3_nxt = lprc_pkg::LPRC_DOM_HALT;
                end
                clocks_nxt = 1'b0;
                wake_en_nxt = (stop_voltage_scale_in
                               == lprc_pkg::LPRC_STOP_VOLTAGE_SCALE_3);
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cpu_r <= lprc_pkg::LPRC_CPU_RUN;
            d1_r <= lprc_pkg::LPRC_DOM_RUN;
            d2_r <= lprc_pkg::LPRC_DOM_RUN;
            d3_r <= lprc_pkg::LPRC_DOM_RUN;
            sys_r <= lprc_pkg::LPRC_SYS_RUN;
            restart_cnt_r <= 4'h0;
            clocks_r <= 1'b1;
            resume_r <= 1'b0;
            vos_r <= lprc_pkg::LPRC_VOS_BOOST;
            stop_voltage_scale_r <= lprc_pkg::LPRC_STOP_VOLTAGE_SCALE_3;
            wake_en_r <= 1'b1;
        end else if (!sys_rst_n_r) begin
            // System reset returns power state to run.
            cpu_r <= lprc_pkg::LPRC_CPU_RUN;
            d1_r <= lprc_pkg::LPRC_DOM_RUN;
            d2_r <= lprc_pkg::LPRC_DOM_RUN;
            d3_r <= lprc_pkg::LPRC_DOM_RUN;
            sys_r <= lprc_pkg::LPRC_SYS_RUN;
            restart_cnt_r <= 4'h0;
            clocks_r <= 1'b1;
            resume_r <= 1'b0;
            vos_r <= vos_nxt;
            stop_voltage_scale_r <= stop_voltage_scale_nxt;
            wake_en_r <= 1'b1;
        end else begin
            cpu_r <= cpu_nxt;
            d1_r <= d1_nxt;
            d2_r <= d2_nxt;
            d3_r <= d3_nxt;
            sys_r <= sys_nxt;
            restart_cnt_r <= restart_cnt_nxt;
            clocks_r <= clocks_nxt;
            resume_r <= resume_nxt;
            vos_r <= vos_nxt;
            stop_voltage_scale_r <= stop_voltage_scale_nxt;
            wake_en_r <= wake_en_nxt;
        end
    end

    // Outputs straight from flops.
    assign cpu_state_out = cpu_r;
    assign cpu_domain_state_out = d1_r;
    assign peripheral_domain_state_out = d2_r;
    assign system_control_domain_state_out = d3_r;
    assign system_state_out = sys_r;
    assign system_reset_n_out = sys_rst_n_r;
    assign por_reset_n_out = por_n_r;
    assign voltage_scale_out = vos_r;
    assign stop_scale_out = stop_voltage_scale_r;
    assign wake_periph_enable_out = wake_en_r;
    assign clk_sel_out = clk_sel_r;
    assign clocks_running_out = clocks_r;
    assign cpu_resume_out = resume_r;

endmodule : lprc_low_power_reset_control

`default_nettype wire

// *** tb/lprc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Core and wakeup-controller model. Each request is one cycle long,
// because a held instruction would re-enter sleep right after a wake.
module lprc_core_model (
    // Clock.
    input wire logic clock_in,
    // Commands from the bench.
    input wire logic sleep_go_in,
    input wire logic [1:0] sleep_kind_in,
    input wire logic wake_go_in,
    // Lines towards the block.
    output logic intr_wait_out,
    output logic evt_wait_out,
    output logic ret_out,
    output logic ret_sleep_out,
    output logic wake_out
);
    // Lines change just after the edge that saw the command. One driver
    // per line, so the lines are quiet from the first edge, inside reset.
    always @(posedge clock_in) begin
        intr_wait_out <= #1 sleep_go_in && sleep_kind_in == 2'h0;
        evt_wait_out <= #1 sleep_go_in && sleep_kind_in == 2'h1;
        ret_out <= #1 sleep_go_in && sleep_kind_in == 2'h2;
        ret_sleep_out <= #1 sleep_kind_in == 2'h2;
        wake_out <= #1 wake_go_in;
    end
endmodule : lprc_core_model

`default_nettype wire

// *** tb/lprc_low_power_reset_control_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port checker; the figures follow the agreed latencies.
module lprc_sva_checker (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Watched inputs.
    input wire logic wait_interrupt_instruction_in,
    input wire logic deep_sleep_in,
    input wire logic wakeup_event_in,
    input wire logic wakeup_pending_in,
    input wire logic cpu_domain_periph_idle_in,
    input wire logic por_low_in,
    input wire logic pdr_low_in,
    input wire logic supervisor_enable_pin_in,
    input wire lprc_pkg::lprc_cause_t cause_in,
    // Watched outputs.
    input wire logic [2:0] cpu_state_out,
    input wire logic [2:0] cpu_domain_state_out,
    input wire logic [2:0] peripheral_domain_state_out,
    input wire logic [2:0] system_control_domain_state_out,
    input wire logic [2:0] system_state_out,
    input wire logic system_reset_n_out,
    input wire logic clocks_running_out,
    input wire logic cpu_resume_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    // Supervisor checks allow six edges for the three-flop synchroniser.
    chk_cpu_halt_entry: assert property (
        system_reset_n_out && wait_interrupt_instruction_in
        && !wakeup_event_in && cpu_state_out == 3'h1 |=>
        cpu_state_out == ($past(deep_sleep_in) ? 3'h4 : 3'h2))
        else $error("cpu did not halt");
    chk_domain_hold: assert property (
        (cpu_state_out != 3'h4 || !cpu_domain_periph_idle_in)
        && cpu_domain_state_out == 3'h1 |=> cpu_domain_state_out == 3'h1)
        else $error("busy domain advanced");
    chk_system_gate: assert property (
        system_state_out == 3'h1 && (wakeup_pending_in
        || cpu_domain_state_out == 3'h1
        || peripheral_domain_state_out == 3'h1) |=> system_state_out == 3'h1)
        else $error("system left run too early");
    chk_run_control: assert property (
        system_state_out == 3'h1 |-> system_control_domain_state_out == 3'h1)
        else $error("control domain not running");
    chk_stop_domains: assert property (
        system_state_out == 3'h2 |-> system_control_domain_state_out == 3'h2
        && cpu_domain_state_out != 3'h1
        && peripheral_domain_state_out != 3'h1)
        else $error("stop with a running domain");
    chk_standby_off: assert property (
        system_state_out == 3'h4 |-> system_control_domain_state_out == 3'h4
        && cpu_domain_state_out == 3'h4
        && peripheral_domain_state_out == 3'h4)
        else $error("standby with a domain powered");
    chk_por_hold: assert property (
        por_low_in [*6] |-> !system_reset_n_out)
        else $error("reset released with low supply");
    chk_pdr_trip: assert property (
        (pdr_low_in && supervisor_enable_pin_in) [*6] |-> !system_reset_n_out)
        else $error("enabled supervisor gave no reset");
    chk_cause_trip: assert property (
        cause_in != 4'h0 |=> !system_reset_n_out)
        else $error("cause gave no reset");
    chk_reset_stretch: assert property (
        $fell(system_reset_n_out) |=> !system_reset_n_out [*7])
        else $error("reset pulse too short");
    chk_resume_order: assert property (
        cpu_resume_out |-> clocks_running_out && $past(clocks_running_out, 4))
        else $error("cpu resumed before clocks");

    // Main scenarios.
    cov_stop: cover property (system_state_out == 3'h2);
    cov_standby: cover property (system_state_out == 3'h4);
    cov_resume: cover property (cpu_resume_out);
endmodule : lprc_sva_checker

bind lprc_low_power_reset_control lprc_sva_checker u_chk (
    .clock_in, .arst_n_in, .wait_interrupt_instruction_in, .deep_sleep_in,
    .wakeup_event_in, .wakeup_pending_in, .cpu_domain_periph_idle_in,
    .por_low_in, .pdr_low_in, .supervisor_enable_pin_in, .cause_in,
    .cpu_state_out, .cpu_domain_state_out, .peripheral_domain_state_out,
    .system_control_domain_state_out, .system_state_out,
    .system_reset_n_out, .clocks_running_out, .cpu_resume_out
);

`default_nettype wire

// *** tb/lprc_low_power_reset_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module lprc_low_power_reset_control_tb;
    // Stimulus and observed lines, named as the block's ports.
    logic clock_in = 1'b0, arst_n_in = 1'b0, sleep_go = 1'b0, wake_go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic wait_interrupt_instruction_in, wait_event_instruction_in;
    logic handler_return_in, sleep_on_handler_return_in, wakeup_event_in;
    logic deep_sleep_in = 1'b1, cpu_domain_periph_idle_in = 1'b1;
    logic peripheral_domain_periph_idle_in = 1'b1;
    logic peripheral_domain_cpu_idle_in = 1'b1, wakeup_pending_in = 1'b0;
    logic cpu_domain_standby_in = 1'b0, peripheral_domain_standby_in = 1'b0;
    logic system_standby_in = 1'b0, por_low_in = 1'b0, pdr_low_in = 1'b0;
    logic supervisor_enable_pin_in = 1'b1, external_reset_pin_n_in = 1'b1;
    logic [2:0] bor_low_in = 3'h0;
    logic [1:0] bor_level_sel_in = 2'h0, run_voltage_scale_in = 2'h0;
    logic [1:0] stop_voltage_scale_in = 2'h0, clk_sel_in = 2'h0;
    logic clk_sel_write_in = 1'b0;
    lprc_pkg::lprc_cause_t cause_in = 4'h0;
    logic [2:0] cpu_state_out, cpu_domain_state_out, system_state_out;
    logic [2:0] peripheral_domain_state_out, system_control_domain_state_out;
    logic system_reset_n_out, por_reset_n_out, wake_periph_enable_out;
    logic [1:0] voltage_scale_out, stop_scale_out, clk_sel_out;
    logic clocks_running_out, cpu_resume_out;
    int comparisons = 0, miscompares = 0, n;

`define CMP(a, b) begin comparisons++; if ((a) !== (b)) begin \
    miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin for (n = 0; n < 40 && !(c); n++) step(); \
    if (!(c)) begin miscompares++; complete_run(); end end

    // 125 MHz clock.
    always #4 clock_in = ~clock_in;

    lprc_core_model u_core (.clock_in, .sleep_go_in(sleep_go),
        .sleep_kind_in(kind), .wake_go_in(wake_go),
        .intr_wait_out(wait_interrupt_instruction_in),
        .evt_wait_out(wait_event_instruction_in),
        .ret_out(handler_return_in),
        .ret_sleep_out(sleep_on_handler_return_in),
        .wake_out(wakeup_event_in));

    lprc_low_power_reset_control uut (.clock_in, .arst_n_in,
        .wait_interrupt_instruction_in, .wait_event_instruction_in,
        .handler_return_in, .sleep_on_handler_return_in, .deep_sleep_in,
        .cpu_domain_periph_idle_in, .peripheral_domain_periph_idle_in,
        .peripheral_domain_cpu_idle_in, .cpu_domain_standby_in,
        .peripheral_domain_standby_in, .system_standby_in,
        .wakeup_pending_in, .wakeup_event_in, .por_low_in, .pdr_low_in,
        .supervisor_enable_pin_in, .bor_low_in, .external_reset_pin_n_in,
        .bor_level_sel_in, .cause_in, .run_voltage_scale_in,
        .stop_voltage_scale_in, .clk_sel_write_in, .clk_sel_in,
        .cpu_state_out, .cpu_domain_state_out, .peripheral_domain_state_out,
        .system_control_domain_state_out, .system_state_out,
        .system_reset_n_out, .por_reset_n_out, .voltage_scale_out,
        .stop_scale_out, .wake_periph_enable_out, .clk_sel_out,
        .clocks_running_out, .cpu_resume_out);

    // Inputs always move 1 ns after the edge, never on it.
    task automatic step();
        @(posedge clock_in);
        #1;
    endtask : step

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic go_sleep(input logic [1:0] k);
        kind = k;
        sleep_go = 1'b1;
        step();
        sleep_go = 1'b0;
        step();
    endtask : go_sleep

    task automatic go_wake();
        wake_go = 1'b1;
        step();
        wake_go = 1'b0;
        `WAITC(cpu_resume_out)
        `CMP(clocks_running_out, 1'b1)
        `CMP(system_state_out, 3'h1)
    endtask : go_wake

    // Clock halt alone leaves the CPU domain running, so no system stop.
    task automatic t_light();
        deep_sleep_in = 1'b0;
        go_sleep(2'h0);
        `CMP(cpu_state_out, 3'h2)
        repeat (3) step();
        `CMP(cpu_domain_state_out, 3'h1)
        `CMP(system_state_out, 3'h1)
        go_wake();
        deep_sleep_in = 1'b1;
        $display("test light done");
    endtask : t_light

    // A busy part or a pending wakeup keeps the deeper states away.
    task automatic t_block();
        cpu_domain_periph_idle_in = 1'b0;
        wakeup_pending_in = 1'b1;
        go_sleep(2'h0);
        repeat (4) step();
        `CMP(cpu_state_out, 3'h4)
        `CMP(cpu_domain_state_out, 3'h1)
        `CMP(peripheral_domain_state_out, 3'h2)
        cpu_domain_periph_idle_in = 1'b1;
        repeat (4) step();
        `CMP(cpu_domain_state_out, 3'h2)
        `CMP(system_state_out, 3'h1)
        wakeup_pending_in = 1'b0;
        `WAITC(system_state_out == 3'h2)
        go_wake();
        $display("test block done");
    endtask : t_block

    task automatic t_sleep(input logic [1:0] k, input logic [1:0] sc);
        stop_voltage_scale_in = sc;
        go_sleep(k);
        `WAITC(system_state_out == 3'h2)
        `CMP(cpu_state_out, 3'h4)
        `CMP(system_control_domain_state_out, 3'h2)
        `CMP(clocks_running_out, 1'b0)
        `CMP(wake_periph_enable_out, sc == 2'h0)
        go_wake();
        $display("test sleep done");
    endtask : t_sleep

    // Waking from standby must come back through a system reset.
    task automatic t_standby();
        {cpu_domain_standby_in, peripheral_domain_standby_in} = 2'h3;
        system_standby_in = 1'b1;
        go_sleep(2'h1);
        `WAITC(system_state_out == 3'h4)
        `CMP(cpu_domain_state_out, 3'h4)
        `CMP(peripheral_domain_state_out, 3'h4)
        {cpu_domain_standby_in, peripheral_domain_standby_in} = 2'h0;
        system_standby_in = 1'b0;
        wake_go = 1'b1;
        step();
        wake_go = 1'b0;
        `WAITC(!system_reset_n_out)
        `WAITC(system_reset_n_out)
        `CMP(system_state_out, 3'h1)
        $display("test standby done");
    endtask : t_standby

    // Each cause must pull reset; the four digital causes must leave the power-on flag alone.
    task automatic t_causes();
        clk_sel_write_in = 1'b1;
        clk_sel_in = 2'h2;
        step();
        clk_sel_write_in = 1'b0;
        step();
        `CMP(clk_sel_out, 2'h2)
        for (int b = 0; b < 4; b++) begin
            cause_in = 4'h1 << b;
            step();
            `CMP(system_reset_n_out, 1'b0)
            cause_in = 4'h0;
            `WAITC(system_reset_n_out)
            `CMP(por_reset_n_out, 1'b1)
        end
        `CMP(clk_sel_out, 2'h0)
        for (int s = 0; s < 4; s++) begin
            bor_level_sel_in = s[1:0];
            bor_low_in = (s == 0) ? 3'h4 : (s == 1) ? 3'h2 : 3'h1;
            repeat (6) step();
            `CMP(system_reset_n_out, 1'b0)
            bor_low_in = 3'h0;
            `WAITC(system_reset_n_out)
            bor_low_in = (s == 0) ? 3'h3 : (s == 1) ? 3'h5 : 3'h6;
            repeat (6) step();
            `CMP(system_reset_n_out, 1'b1)
            bor_low_in = 3'h0;
        end
        {supervisor_enable_pin_in, pdr_low_in} = 2'h1;
        repeat (6) step();
        `CMP(system_reset_n_out, 1'b1)
        supervisor_enable_pin_in = 1'b1;
        repeat (6) step();
        `CMP(system_reset_n_out, 1'b0)
        pdr_low_in = 1'b0;
        `WAITC(system_reset_n_out)
        external_reset_pin_n_in = 1'b0;
        repeat (6) step();
        `CMP(system_reset_n_out, 1'b0)
        external_reset_pin_n_in = 1'b1;
        `WAITC(system_reset_n_out)
        por_low_in = 1'b1;
        repeat (6) step();
        `CMP(por_reset_n_out, 1'b0)
        `CMP(system_reset_n_out, 1'b0)
        por_low_in = 1'b0;
        `WAITC(system_reset_n_out)
        $display("test causes done");
    endtask : t_causes

    task automatic t_scales();
        for (int v = 0; v < 4; v++) begin
            {run_voltage_scale_in, stop_voltage_scale_in} = {v[1:0], v[1:0]};
            repeat (2) step();
            `CMP(voltage_scale_out, v[1:0])
            `CMP(stop_scale_out, v[1:0])
        end
        stop_voltage_scale_in = 2'h0;
        $display("test scales done");
    endtask : t_scales

    // Main sequence.
    initial begin
        repeat (4) @(posedge clock_in);
        #1 arst_n_in = 1'b1;
        `WAITC(system_reset_n_out)
        `CMP(clk_sel_out, 2'h0)
        `CMP(system_state_out, 3'h1)
        t_scales();
        t_light();
        t_block();
        t_sleep(2'h1, 2'h0);
        t_sleep(2'h2, 2'h2);
        t_standby();
        t_causes();
        complete_run();
    end
endmodule : lprc_low_power_reset_control_tb

`default_nettype wire
